// >>> verilog/sdb_pkg.sv
`default_nettype none
package sdb_pkg;
    // register byte addresses
    localparam logic [7:0] SDB_CDB_LO = 8'h00;
    localparam logic [7:0] SDB_CDB_MID = 8'h04;
    localparam logic [7:0] SDB_CDB_HI = 8'h08;
    localparam logic [7:0] SDB_CTRL = 8'h0c;
    localparam logic [7:0] SDB_STAT = 8'h10;
    localparam logic [7:0] SDB_COUNT = 8'h14;
    // field positions
    localparam int SDB_CTRL_START = 0;
    localparam int SDB_ST_BUSY = 0;
    localparam int SDB_ST_DONE = 1;
    localparam int SDB_ST_CODE = 8;
    localparam int SDB_ST_SENSE = 16;
    localparam int SDB_ST_REFUSED = 24;
    // command opcodes and modes
    localparam logic [7:0] SDB_OP_WRBUF = 8'h3b;
    localparam logic [7:0] SDB_OP_RDBUF = 8'h3c;
    localparam logic [2:0] SDB_MODE_COMB = 3'h0;
    localparam logic [2:0] SDB_MODE_DATA = 3'h2;
    localparam logic [2:0] SDB_MODE_DESC = 3'h3;
    // completion status and sense
    localparam logic [7:0] SDB_STAT_GOOD = 8'h00;
    localparam logic [7:0] SDB_STAT_CHECK = 8'h02;
    localparam logic [7:0] SDB_STAT_BUSY = 8'h08;
    localparam logic [7:0] SDB_STAT_RESV = 8'h18;
    localparam logic [3:0] SDB_SENSE_NONE = 4'h0;
    localparam logic [3:0] SDB_SENSE_ILLEGAL = 4'h5;
    localparam logic [23:0] SDB_HDR_LEN = 24'h000004;
    localparam logic [2:0] SDB_HSIZE_WORD = 3'h2;
    localparam int SDB_BUF_BYTES = 16384;

    typedef enum logic [1:0] {S_IDLE, S_XFER, S_DONE} sdb_fsm_e;

    typedef struct packed {
        sdb_fsm_e fsm;
        logic rd;
        logic hdr;
        logic hzero;
        logic [23:0] base;
        logic [23:0] total;
        logic [23:0] idx;
        logic din_valid;
        logic [7:0] din_byte;
        logic [7:0] code;
        logic [3:0] sense;
        logic [7:0] refused;
        logic [79:0] cdb;
        logic a_pend;
        logic a_wr;
        logic a_rdy;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
    } sdb_state_s;

    localparam sdb_state_s SDB_ST_RST = '0;
endpackage
`default_nettype wire

// >>> verilog/sdb_cmd_handler.sv
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module sdb_cmd_handler
    import sdb_pkg::*;
#(
    parameter int BUF_BYTES = SDB_BUF_BYTES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // ahb-lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // reservation held by another initiator
    input wire logic resv_conflict,
    // data-out bytes from the initiator
    input wire logic dout_valid,
    input wire logic [7:0] dout_byte,
    output logic dout_ready,
    // data-in bytes to the initiator
    output logic din_valid,
    output logic [7:0] din_byte,
    input wire logic din_ready
);
    localparam int AW = $clog2(BUF_BYTES);
    localparam logic [23:0] BUF_LEN = 24'(BUF_BYTES);

    // header counts are 24 bits wide, so the buffer plus header must fit
    if (BUF_BYTES < 4 || BUF_BYTES > 24'hfffff0) begin : g_chk
        $error("BUF_BYTES out of range");
    end

    sdb_state_s st;
    sdb_state_s next_st;
    logic [7:0] mem [BUF_BYTES];
    logic mem_we;
    logic [AW-1:0] mem_wa;
    logic start;

    ////////////////////////////////////////////////////////////////////
    // command descriptor fields
    logic [7:0] op;
    logic [2:0] mode;
    logic [7:0] buf_id;
    logic [23:0] off;
    logic [23:0] len;
    logic [24:0] span;
    logic [24:0] buf_p4;
    assign op = st.cdb[7:0];
    assign mode = st.cdb[10:8];
    assign buf_id = st.cdb[23:16];
    assign off = {st.cdb[31:24], st.cdb[39:32], st.cdb[47:40]};
    assign len = {st.cdb[55:48], st.cdb[63:56], st.cdb[71:64]};
    assign span = {1'b0, off} + {1'b0, len};
    assign buf_p4 = {1'b0, BUF_LEN} + {1'b0, SDB_HDR_LEN};

    // decode: legality, byte count, start address, header presence
    logic chk_ok;
    logic dec_rd;
    logic dec_hdr;
    logic [23:0] dec_total;
    logic [23:0] dec_base;
    always_comb begin
        chk_ok = 1'b1;
        dec_rd = (op == SDB_OP_RDBUF);
        dec_hdr = 1'b0;
        dec_total = len;
        dec_base = off;
        if (op == SDB_OP_WRBUF && mode == SDB_MODE_COMB) begin
            chk_ok = ({1'b0, len} <= buf_p4);
            dec_hdr = 1'b1;
            dec_base = '0;
        end else if (op == SDB_OP_WRBUF && mode == SDB_MODE_DATA) begin
            chk_ok = (buf_id == 8'h00) && (span <= {1'b0, BUF_LEN});
        end else if (op == SDB_OP_RDBUF && mode == SDB_MODE_COMB) begin
            dec_hdr = 1'b1;
            dec_base = '0;
            // whichever is less: allocation or all header plus data
            if ({1'b0, len} > buf_p4) begin
                dec_total = buf_p4[23:0];
            end
        end else if (op == SDB_OP_RDBUF && mode == SDB_MODE_DATA) begin
            // overflow refused rather than wrapped into the buffer
            chk_ok = (buf_id == 8'h00) && (span <= {1'b0, BUF_LEN});
        end else if (op == SDB_OP_RDBUF && mode == SDB_MODE_DESC) begin
            dec_hdr = 1'b1;
            if (len > SDB_HDR_LEN) begin
                dec_total = SDB_HDR_LEN;
            end
        end else begin
            chk_ok = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // byte offered on data-in and buffer address of the current byte
    logic [23:0] mem_ix;
    logic in_hdr;
    logic [7:0] rd_byte;
    logic [23:0] cap;
    assign in_hdr = st.hdr && (st.idx < SDB_HDR_LEN);
    assign mem_ix = st.base + st.idx - (st.hdr ? SDB_HDR_LEN : 24'h0);
    assign cap = st.hzero ? 24'h0 : BUF_LEN;
    always_comb begin
        rd_byte = mem[mem_ix[AW-1:0]];
        if (in_hdr) begin
            unique case (st.idx[1:0])
                2'h0: rd_byte = 8'h00;
                2'h1: rd_byte = cap[23:16];
                2'h2: rd_byte = cap[15:8];
                2'h3: rd_byte = cap[7:0];
            endcase
        end
    end

    // register read word
    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        case (st.a_addr)
            SDB_CDB_LO: rd_word = st.cdb[31:0];
            SDB_CDB_MID: rd_word = st.cdb[63:32];
            SDB_CDB_HI: rd_word = {16'h0000, st.cdb[79:64]};
            SDB_STAT: begin
                rd_word[SDB_ST_BUSY] = (st.fsm == S_XFER);
                rd_word[SDB_ST_DONE] = (st.fsm == S_DONE);
                rd_word[SDB_ST_CODE +: 8] = st.code;
                rd_word[SDB_ST_SENSE +: 4] = st.sense;
                rd_word[SDB_ST_REFUSED +: 8] = st.refused;
            end
            SDB_COUNT: rd_word = {8'h00, st.idx};
            default: rd_word = '0;
        endcase
    end

    // reads wait one cycle so a write just before is seen
    assign hreadyout = !(st.a_pend && !st.a_wr && !st.a_rdy);
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;
    assign din_valid = st.din_valid;
    assign din_byte = st.din_byte;
    assign dout_ready = (st.fsm == S_XFER) && !st.rd && (st.idx != st.total);
    assign start = st.a_pend && st.a_wr && (st.a_addr == SDB_CTRL)
        && hwdata[SDB_CTRL_START];

    ////////////////////////////////////////////////////////////////////
    // next state: bus slave, command start, byte transfer
    always_comb begin
        next_st = st;
        mem_we = 1'b0;
        mem_wa = mem_ix[AW-1:0];
        if (st.a_pend && st.a_wr) begin
            case (st.a_addr)
                SDB_CDB_LO: next_st.cdb[31:0] = hwdata;
                SDB_CDB_MID: next_st.cdb[63:32] = hwdata;
                SDB_CDB_HI: next_st.cdb[79:64] = hwdata[15:0];
                default: next_st.cdb = st.cdb;
            endcase
        end
        if (st.a_pend && !st.a_wr && !st.a_rdy) begin
            next_st.hrdata = rd_word;
            next_st.a_rdy = 1'b1;
        end
        if (hready) begin
            next_st.a_pend = hsel && htrans[1];
            next_st.a_wr = hwrite && (hsize == SDB_HSIZE_WORD);
            next_st.a_addr = haddr[7:0];
            next_st.a_rdy = 1'b0;
        end
        // a running command keeps going; the new one is refused
        // without stalling the byte handshake on the same edge
        if (start && st.fsm == S_XFER) begin
            next_st.refused = SDB_STAT_BUSY;
        end
        if (start && st.fsm != S_XFER) begin
            next_st.refused = SDB_STAT_GOOD;
            next_st.rd = dec_rd;
            next_st.hdr = dec_hdr;
            next_st.hzero = (mode == SDB_MODE_DESC) && (buf_id != 8'h00);
            next_st.base = dec_base;
            next_st.total = dec_total;
            next_st.idx = '0;
            next_st.din_valid = 1'b0;
            next_st.sense = SDB_SENSE_NONE;
            if (resv_conflict) begin
                next_st.fsm = S_DONE;
                next_st.code = SDB_STAT_RESV;
            end else if (!chk_ok) begin
                next_st.fsm = S_DONE;
                next_st.code = SDB_STAT_CHECK;
                next_st.sense = SDB_SENSE_ILLEGAL;
            end else begin
                next_st.fsm = S_XFER;
            end
        end else if (st.fsm == S_XFER) begin
            if (st.idx == st.total) begin
                next_st.fsm = S_DONE;
                next_st.code = SDB_STAT_GOOD;
            end else if (st.rd) begin
                // one bubble per byte keeps the data output a flop
                if (!st.din_valid) begin
                    next_st.din_valid = 1'b1;
                    next_st.din_byte = rd_byte;
                end else if (din_ready) begin
                    next_st.din_valid = 1'b0;
                    next_st.idx = st.idx + 24'h1;
                end
            end else if (dout_valid) begin
                next_st.idx = st.idx + 24'h1;
                mem_we = !in_hdr;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= SDB_ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // buffer storage, not reset: contents survive for diagnostics
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_wa] <= dout_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    logic go;
    assign go = start && st.fsm != S_XFER && !resv_conflict;

    sequence s_finish;
        st.fsm == S_DONE && !st.din_valid;
    endsequence

    sequence s_good;
        s_finish ##0 st.code == SDB_STAT_GOOD;
    endsequence

    property p_reject;
        go && !chk_ok |=> s_finish ##0 st.code == SDB_STAT_CHECK
            && st.sense == SDB_SENSE_ILLEGAL;
    endproperty
    a_reject: assert property (p_reject)
        else $error("rejected command did not end in check");

    property p_busy;
        start && st.fsm == S_XFER |=> st.fsm == S_XFER
            && st.refused == SDB_STAT_BUSY;
    endproperty
    a_busy: assert property (p_busy)
        else $error("start while busy not refused");

    property p_resv;
        start && st.fsm != S_XFER && resv_conflict
            |=> s_finish ##0 st.code == SDB_STAT_RESV;
    endproperty
    a_resv: assert property (p_resv)
        else $error("conflict status missing");

    property p_zero;
        go && chk_ok && len == 24'h0 |=> st.fsm == S_XFER ##1 s_good;
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero length did not finish at once");

    property p_desc;
        go && chk_ok && dec_rd && mode == SDB_MODE_DESC
            |=> st.total <= SDB_HDR_LEN;
    endproperty
    a_desc: assert property (p_desc)
        else $error("descriptor longer than four bytes");

    property p_hdr0;
        st.din_valid && st.hdr && st.idx == 24'h0 |-> st.din_byte == 8'h00;
    endproperty
    a_hdr0: assert property (p_hdr0)
        else $error("header byte 0 not zero");

    property p_cap;
        st.din_valid && st.hdr && st.idx == 24'h3 && !st.hzero
            |-> st.din_byte == BUF_LEN[7:0];
    endproperty
    a_cap: assert property (p_cap)
        else $error("capacity byte wrong");

    property p_skip;
        dout_valid && dout_ready && st.hdr && st.idx < SDB_HDR_LEN |-> !mem_we;
    endproperty
    a_skip: assert property (p_skip)
        else $error("header byte stored");

    property p_hold;
        st.din_valid && !din_ready && st.fsm == S_XFER
            |=> st.din_valid && $stable(st.din_byte);
    endproperty
    a_hold: assert property (p_hold)
        else $error("data-in byte dropped");

    property p_end;
        st.fsm == S_XFER && st.idx == st.total && !start |=> s_good;
    endproperty
    a_end: assert property (p_end)
        else $error("transfer did not end with good status");
endmodule
`default_nettype wire

// >>> sim/sdb_init_model.sv
`timescale 1ns/100ps
`default_nettype none
// initiator side of the data-out and data-in byte streams
module sdb_init_model
    import sdb_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // stall request from the bench
    input wire logic stall,
    // data-out toward the block
    input wire logic dout_ready,
    output logic dout_valid,
    output logic [7:0] dout_byte,
    // data-in from the block
    output logic din_ready
);
    logic [15:0] k;
    logic [7:0] pat;
    // byte k of the outgoing stream; the bench mirrors this formula
    assign pat = k[7:0] * 8'h07 + 8'h11;
    // idle line shows the inverse, so a stale byte is never stored
    assign dout_byte = dout_valid ? pat : ~pat;
    // a byte and its valid hold until taken
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            k <= '0;
            dout_valid <= 1'b0;
            din_ready <= 1'b0;
        end else begin
            if (dout_valid && dout_ready) begin
                k <= k + 16'h1;
            end
            if (!dout_valid || dout_ready) begin
                dout_valid <= !stall;
            end
            din_ready <= !stall;
        end
    end
endmodule
`default_nettype wire

// >>> sim/scsi_data_buffer_cmd_handler_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module scsi_data_buffer_cmd_handler_tb_top
    import sdb_pkg::*;
();
    localparam int BB = 64;
    logic clk_sys, reset, hsel, hwrite, hreadyout, hresp, resv, stall;
    logic [31:0] haddr, hwdata, hrdata, st;
    // seed set once here so only the stall process ever writes it
    logic [31:0] rnd = 32'h57ef1c30;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic dout_valid, dout_ready, din_valid, din_ready;
    logic [7:0] dout_byte, din_byte;
    logic [7:0] mem [BB];
    logic [7:0] q [$];
    int mismatches, n_checks, k, nout;
    // refused commands: opcode, mode, id, offset, length
    logic [7:0] rop [6] = '{8'h3b, 8'h3b, 8'h3b, 8'h3c, 8'h3b, 8'h3b};
    logic [2:0] rmd [6] = '{3'h0, 3'h2, 3'h2, 3'h2, 3'h1, 3'h3};
    logic [7:0] rid [6] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [23:0] rof [6] = '{24'h0, 24'h0, 24'h3c, 24'h0, 24'h0, 24'h0};
    logic [23:0] rln [6] = '{24'h45, 24'h4, 24'h8, 24'h4, 24'h4, 24'h4};

    sdb_cmd_handler #(.BUF_BYTES(BB)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .resv_conflict(resv), .dout_valid(dout_valid),
        .dout_byte(dout_byte), .dout_ready(dout_ready),
        .din_valid(din_valid), .din_byte(din_byte), .din_ready(din_ready)
    );
    sdb_init_model u_init (
        .clk_sys(clk_sys), .reset(reset), .stall(stall),
        .dout_ready(dout_ready), .dout_valid(dout_valid),
        .dout_byte(dout_byte), .din_ready(din_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] patf(input int n);
        return n[7:0] * 8'h07 + 8'h11;
    endfunction
    task report_and_stop;
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    // bounded wait for hready at a rising edge
    task wrdy;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            if (hreadyout === 1'b1) begin
                return;
            end
        end
        chk("hreadyout", 1, hreadyout);
        report_and_stop;
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= SDB_HSIZE_WORD;
        wrdy;
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wrdy;
        r = hrdata;
    endtask
    // mirror of stored bytes, and expected data-in notes
    task wm(input int o, input int n);
        for (int i = 0; i < n; i++) begin
            mem[o + i] = patf(k + i);
        end
        k += n;
    endtask
    task pm(input int o, input int n);
        for (int i = 0; i < n; i++) begin
            q.push_back(mem[o + i]);
        end
    endtask
    task ph(input int n, input logic z);
        logic [31:0] h;
        h = z ? 32'h0 : {8'h00, 24'(BB)};
        for (int i = 0; i < n; i++) begin
            q.push_back(h[31 - 8 * i -: 8]);
        end
    endtask
    task cmd(input logic [7:0] op, input logic [2:0] m, input logic [7:0] id,
             input logic [23:0] o, input logic [23:0] l,
             input logic [7:0] code, input logic dbl);
        logic [31:0] r;
        int i;
        ahb(1'b1, SDB_CDB_LO, {o[23:16], id, 5'h0, m, op}, r);
        ahb(1'b1, SDB_CDB_MID, {l[15:8], l[23:16], o[7:0], o[15:8]}, r);
        ahb(1'b1, SDB_CDB_HI, {24'h0, l[7:0]}, r);
        ahb(1'b1, SDB_CTRL, 32'h1, r);
        if (dbl) begin
            ahb(1'b1, SDB_CTRL, 32'h1, r);
        end
        // let the start land before status is polled
        repeat (2) @(posedge clk_sys);
        for (i = 0; i < 400; i++) begin
            ahb(1'b0, SDB_STAT, 32'h0, st);
            if (st[1:0] === 2'b10) begin
                break;
            end
        end
        chk("done", 2'b10, st[1:0]);
        if (i == 400) begin
            report_and_stop;
        end
        chk("code", code, st[15:8]);
        if (code != SDB_STAT_RESV) begin
            chk("sense", code == SDB_STAT_CHECK ? 4'h5 : 4'h0, st[19:16]);
        end
        chk("refused", dbl ? SDB_STAT_BUSY : 8'h00, st[31:24]);
        chk("din_left", 0, q.size());
        chk("dout_count", k, nout);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // random stalls on both streams
    always @(posedge clk_sys) begin
        rnd <= xs(rnd);
        stall <= rnd[0] & rnd[1];
    end
    // result watcher: each data-in byte against the oldest note
    always @(posedge clk_sys) begin
        if (dout_valid === 1'b1 && dout_ready === 1'b1) begin
            nout++;
        end
        if (din_valid === 1'b1 && din_ready === 1'b1) begin
            if (q.size() == 0) begin
                chk("din_extra", 32'hffff, {24'h0, din_byte});
            end else begin
                chk("din_byte", q.pop_front(), din_byte);
            end
        end
    end
    initial begin
        logic [31:0] r;
        int o;
        int a;
        {hsel, haddr, htrans, hwrite, hsize, hwdata, resv} = '0;
        {k, nout, mismatches, n_checks} = '0;
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        ahb(1'b1, 8'h20, 32'hffffffff, r);
        ahb(1'b0, 8'h20, 32'h0, r);
        chk("unmapped", 32'h0, r);
        o = int'(rnd[4:0]);
        wm(o, 16);
        cmd(SDB_OP_WRBUF, SDB_MODE_DATA, 8'h0, 24'(o), 24'd16, 8'h00, 1'b0);
        wm(48, 16);
        cmd(SDB_OP_WRBUF, SDB_MODE_DATA, 8'h0, 24'd48, 24'd16, 8'h00, 1'b0);
        pm(o, 16);
        cmd(SDB_OP_RDBUF, SDB_MODE_DATA, 8'h0, 24'(o), 24'd16, 8'h00, 1'b0);
        k += 4;
        wm(0, BB);
        cmd(SDB_OP_WRBUF, SDB_MODE_COMB, 8'h5, 24'h7, 24'(BB + 4), 8'h00, 1'b0);
        foreach (rln[i]) begin
            cmd(rop[i], rmd[i], rid[i], rof[i], rln[i], SDB_STAT_CHECK, 1'b0);
        end
        foreach (rid[i]) begin
            a = (i == 0) ? 70 : (i == 1) ? 6 : (i == 2) ? 3 : 0;
            ph(a < 4 ? a : 4, 1'b0);
            pm(0, a > 4 ? (a - 4 < BB ? a - 4 : BB) : 0);
            cmd(SDB_OP_RDBUF, SDB_MODE_COMB, 8'h9, 24'h3, 24'(a), 8'h00, 1'b0);
        end
        ph(4, 1'b0);
        cmd(SDB_OP_RDBUF, SDB_MODE_DESC, 8'h0, 24'h0, 24'd9, 8'h00, 1'b0);
        ph(4, 1'b1);
        cmd(SDB_OP_RDBUF, SDB_MODE_DESC, 8'h2, 24'h0, 24'd9, 8'h00, 1'b0);
        ph(2, 1'b0);
        cmd(SDB_OP_RDBUF, SDB_MODE_DESC, 8'h0, 24'h0, 24'd2, 8'h00, 1'b0);
        resv <= 1'b1;
        cmd(SDB_OP_WRBUF, SDB_MODE_DATA, 8'h0, 24'h0, 24'd4, SDB_STAT_RESV, 1'b0);
        resv <= 1'b0;
        pm(0, BB);
        cmd(SDB_OP_RDBUF, SDB_MODE_DATA, 8'h0, 24'h0, 24'(BB), 8'h00, 1'b1);
        ahb(1'b0, SDB_COUNT, 32'h0, r);
        chk("count", BB, r);
        report_and_stop;
    end
endmodule
`default_nettype wire
